// file: pkg/sync_sel_pkg.sv
// Package for the sync source selector: register map, fields, timing and types
package sync_sel_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets (APB, one aligned word each)
    localparam logic [7:0] ctrl_off   = 8'h00; // Mode, preferred input, rate
    localparam logic [7:0] status_off = 8'h04; // Per-input lock/sync, active ref
    localparam logic [7:0] freq_off   = 8'h08; // Measured frequency of active ref
    localparam logic [7:0] irq_st_off = 8'h0c; // Sticky event bits (read only)
    localparam logic [7:0] irq_cl_off = 8'h10; // Write one to clear (write only)
    localparam logic [7:0] irq_en_off = 8'h14; // Interrupt enables
    localparam logic [7:0] rate_off   = 8'h18; // Current internal rate in Hz

    ////////////////////////////////////////////////////////////////////////
    // Control field positions
    localparam int ctrl_auto_bit  = 0;  // 1 = automatic reference mode
    localparam int ctrl_pref_lsb  = 4;  // Preferred input index, 2 bits
    localparam int ctrl_mult_lsb  = 8;  // Word clock ratio select, 3 bits
    localparam int ctrl_rate_lsb  = 12; // Master rate in Hz, 18 bits
    localparam int ctrl_opt_bit   = 31; // Optional video/timecode module fitted

    // Reset values
    localparam logic [31:0] ctrl_reset   = 32'h0000_0001;
    localparam logic [17:0] rate_reset   = 18'h0bb80; // 48000 Hz
    localparam logic [3:0]  irq_en_reset = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Inputs and limits
    localparam int          num_inputs = 4;          // Word clock, serial audio, video, timecode
    localparam logic [1:0]  in_word    = 2'h0;
    localparam logic [1:0]  in_serial  = 2'h1;
    localparam logic [1:0]  in_video   = 2'h2;
    localparam logic [1:0]  in_ltc     = 2'h3;
    localparam logic [17:0] lock_min_hz = 18'h06d60; // 28000 Hz
    localparam logic [17:0] lock_max_hz = 18'h30d40; // 200000 Hz

    // Interrupt event bits
    localparam int irq_ref_change = 0; // Active reference changed
    localparam int irq_to_master  = 1; // Fell back to master
    localparam int irq_lock_lost  = 2; // An input lost lock
    localparam int irq_lock_gain  = 3; // An input gained lock

    ////////////////////////////////////////////////////////////////////////
    // Timing: frequency measured over a gate time
    localparam int gate_time_ms   = 1;
    localparam int clk_hz         = 20_000_000;
    localparam int gate_cycles    = clk_hz / 1000 * gate_time_ms; // 20000
    localparam int gate_per_sec   = 1000 / gate_time_ms;          // Edges to Hz

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {no_lock = 2'h0, locked = 2'h1, in_sync = 2'h2} sync_state_e;
    typedef enum logic [1:0] {st_master = 2'b01, st_slave = 2'b10} clk_mode_e;

    typedef struct packed {
        logic [31:0] pwdata;
        logic [7:0]  paddr;
        logic        pwrite;
        logic        psel;
        logic        penable;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;

endpackage : sync_sel_pkg

// file: verilog/sync_source_selector.sv
// Sync source selector: automatic clock reference choice, lock/sync report, APB regs
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Automatic mode takes first valid input
// - Valid preferred input stays the source
// - Invalid preferred: scan other inputs in turn
// - No valid input: switch to master
// - Lock any rate 28 to 200 kHz
// - Word clock ratio half to quad
// - Report active input and its frequency
// - Per input: no lock, lock, sync
// - Master rate write applies at once; the code applies it in master mode only and ignores it while slave
// - Fallback rate: nearest standard frequency
// - Candidates word, serial, optional video/timecode
module sync_source_selector
    import sync_sel_pkg::*;
(
    // Clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   reset_n_in,
    // APB slave
    input  wire sync_sel_pkg::apb_req_s apb_in,
    output var  sync_sel_pkg::apb_rsp_s apb_out,
    // Reference frame pulses from the inputs (asynchronous)
    input  wire logic [3:0]             ref_tick_in,
    // Local sample clock tick from the rate generator
    input  wire logic                   sys_tick_in,
    // Clock state to the rate generator
    output logic                        slave_mode_out,
    output logic [1:0]                  active_ref_out,
    output logic [17:0]                 master_rate_out,
    output logic [2:0]                  word_ratio_out,
    // Interrupt
    output logic                        irq_out
);
    import sync_sel_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0]       ctrl;                 // Software control word
    logic [3:0]        irq_st;               // Sticky events
    logic [3:0]        irq_en;               // Event enables
    logic [17:0]       rate;                 // Internal master rate
    clk_mode_e         mode;                 // Current clock mode
    logic [1:0]        active;               // Active reference index
    logic [3:0]        sync1, sync2, tick_d; // Synchroniser and edge detect
    logic [3:0]        tick;                 // One-cycle edge per input
    logic              sys_d;                // Local tick delay
    logic [14:0]       gate_cnt;             // Gate time counter
    logic [17:0]       edge_cnt [num_inputs];// Edges in current gate
    logic [17:0]       freq [num_inputs];    // Last measured frequency
    logic [3:0]        valid;                // Locked inputs
    logic [3:0]        valid_d;              // Previous lock state
    logic [3:0]        phase_ok;             // Edge met local tick
    logic [3:0]        cand;                 // Candidate mask
    logic [1:0]        next_active;
    logic              next_found;
    logic              gate_end;
    logic [1:0]        pref;
    sync_state_e       st [num_inputs];

    assign pref = ctrl[ctrl_pref_lsb +: 2];
    assign word_ratio_out = ctrl[ctrl_mult_lsb +: 3];
    assign gate_end = (gate_cnt == 15'(gate_cycles - 1));

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchroniser then edge detect on the third stage
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            sync1  <= 4'h0;
            sync2  <= 4'h0;
            tick_d <= 4'h0;
            sys_d  <= 1'b0;
        end else begin
            sync1  <= ref_tick_in;
            sync2  <= sync1;
            tick_d <= sync2;
            sys_d  <= sys_tick_in;
        end
    end
    assign tick = sync2 & ~tick_d;

    ////////////////////////////////////////////////////////////////////////
    // Gate timer: every gate converts edge counts into Hz
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in || gate_end) begin
            gate_cnt <= 15'h0000;
        end else begin
            gate_cnt <= gate_cnt + 15'h0001;
        end
    end

    // Candidate mask: optional inputs only when the module is fitted
    assign cand = ctrl[ctrl_opt_bit] ? 4'hf : 4'h3;

    genvar gi;
    generate
        for (gi = 0; gi < num_inputs; gi++) begin : g_meas
            // Count edges and latch Hz at gate end; saturating to avoid wrap
            always_ff @(posedge core_clk_in) begin
                if (!reset_n_in) begin
                    edge_cnt[gi] <= 18'h00000;
                    freq[gi]     <= 18'h00000;
                end else if (gate_end) begin
                    edge_cnt[gi] <= 18'(tick[gi]);
                    // Saturate: a wrapped product could fake a rate inside the lock window
                    freq[gi]     <= (edge_cnt[gi] > 18'h00106) ? 18'h3ffff
                                                               : 18'(edge_cnt[gi] * gate_per_sec);
                end else if (tick[gi] && edge_cnt[gi] != 18'h3ffff) begin
                    edge_cnt[gi] <= edge_cnt[gi] + 18'h00001;
                end
            end
            // Lock to any rate inside the window, not only standard rates
            assign valid[gi] = cand[gi] && freq[gi] >= lock_min_hz && freq[gi] <= lock_max_hz;
            // Phase check: reference edge must coincide with a local tick
            always_ff @(posedge core_clk_in) begin
                if (!reset_n_in) begin
                    phase_ok[gi] <= 1'b0;
                end else if (tick[gi]) begin
                    phase_ok[gi] <= sys_d;
                end
            end
            // Three-state report
            always_comb begin
                if (!valid[gi]) begin
                    st[gi] = no_lock;
                end else if (phase_ok[gi] && mode == st_slave && active == 2'(gi)
                             && freq[gi] == rate) begin
                    st[gi] = in_sync;
                end else begin
                    st[gi] = locked;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Selection: preferred first, then scan the rest upward from the preferred index, wrapping past 3
    always_comb begin
        next_active = pref;
        next_found  = 1'b0;
        if (valid[pref]) begin
            next_found = 1'b1;
        end else begin
            for (int i = 1; i < num_inputs; i++) begin
                if (!next_found && valid[2'(pref + 2'(i))]) begin
                    next_active = 2'(pref + 2'(i));
                    next_found  = 1'b1;
                end
            end
        end
    end

    // Mode and reference: automatic mode follows the scan, else master
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            mode   <= st_master;
            active <= in_word;
        end else if (ctrl[ctrl_auto_bit] && next_found) begin
            mode   <= st_slave;
            active <= next_active;
        end else begin
            mode   <= st_master;
        end
    end

    // Nearest standard rate for a frequency
    function automatic logic [17:0] nearest_std(input logic [17:0] f);
        logic [17:0] r;
        r = 18'h0bb80;
        if      (f < 18'h094a2) r = 18'h07d00; // 32000
        else if (f < 18'h0b3e2) r = 18'h0ac44; // 44100
        else if (f < 18'h0dac0) r = 18'h0bb80; // 48000
        else if (f < 18'h12944) r = 18'h0fa00; // 64000
        else if (f < 18'h167c4) r = 18'h15888; // 88200
        else if (f < 18'h21408) r = 18'h17700; // 96000
        else if (f < 18'h2cf88) r = 18'h2b110; // 176400
        else                    r = 18'h2ee00; // 192000
        return r;
    endfunction : nearest_std

    ////////////////////////////////////////////////////////////////////////
    // APB access: zero wait states, error on unmapped address
    logic wr_en, rd_en;
    logic hit;
    assign wr_en = apb_in.psel && apb_in.penable && apb_in.pwrite;
    assign rd_en = apb_in.psel && !apb_in.pwrite;
    always_comb begin
        unique case (apb_in.paddr)
            ctrl_off, status_off, freq_off, irq_st_off, irq_cl_off, irq_en_off, rate_off: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Internal rate: host writes apply at once in master mode only, fallback snaps to standard
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            rate <= rate_reset;
        end else if (mode == st_slave && !(ctrl[ctrl_auto_bit] && next_found)) begin
            // The measured value already shows the loss; the tracked rate still holds the last good one
            rate <= nearest_std(rate);
        end else if (mode == st_slave) begin
            rate <= freq[active];
        end else if (wr_en && apb_in.paddr == ctrl_off) begin
            rate <= apb_in.pwdata[ctrl_rate_lsb +: 18];
        end
    end

    // Control and enable registers
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            ctrl   <= ctrl_reset;
            irq_en <= irq_en_reset;
        end else if (wr_en) begin
            if (apb_in.paddr == ctrl_off)   ctrl   <= apb_in.pwdata;
            if (apb_in.paddr == irq_en_off) irq_en <= apb_in.pwdata[3:0];
        end
    end

    // Sticky events: a set in the clearing cycle wins
    logic [3:0] ev;
    assign ev[irq_ref_change] = mode == st_slave && ctrl[ctrl_auto_bit] && next_found && next_active != active;
    assign ev[irq_to_master]  = mode == st_slave && !(ctrl[ctrl_auto_bit] && next_found);
    assign ev[irq_lock_lost]  = |(valid_d & ~valid);
    assign ev[irq_lock_gain]  = |(valid & ~valid_d);
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            irq_st  <= 4'h0;
            valid_d <= 4'h0;
        end else begin
            valid_d <= valid;
            irq_st  <= (irq_st & ~((wr_en && apb_in.paddr == irq_cl_off) ? apb_in.pwdata[3:0] : 4'h0)) | ev;
        end
    end
    assign irq_out = |(irq_st & irq_en);

    // Read data registered during setup, valid in access phase
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            apb_out.prdata <= 32'h0000_0000;
        end else if (rd_en && !apb_in.penable) begin
            unique case (apb_in.paddr)
                ctrl_off:   apb_out.prdata <= ctrl;
                status_off: apb_out.prdata <= {20'h00000, 1'b0, mode == st_slave, active,
                                               st[3], st[2], st[1], st[0]};
                freq_off:   apb_out.prdata <= {14'h0000, freq[active]};
                irq_st_off: apb_out.prdata <= {28'h0000000, irq_st};
                irq_en_off: apb_out.prdata <= {28'h0000000, irq_en};
                rate_off:   apb_out.prdata <= {14'h0000, rate};
                default:    apb_out.prdata <= 32'h0000_0000;
            endcase
        end
    end
    assign apb_out.pready  = 1'b1;
    assign apb_out.pslverr = apb_in.psel && apb_in.penable && !hit;

    // Outputs to the rate generator
    assign slave_mode_out  = (mode == st_slave);
    assign active_ref_out  = active;
    assign master_rate_out = rate;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    pref_kept_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        ctrl[ctrl_auto_bit] && valid[pref] |=> active == $past(pref) && mode == st_slave)
        else $error("preferred valid input not kept");
    to_master_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (valid & cand) == 4'h0 |=> mode == st_master)
        else $error("no valid input but not master");
    scan_valid_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        ctrl[ctrl_auto_bit] && !valid[pref] && valid != 4'h0 |=> mode == st_slave && $past(valid[next_active]))
        else $error("scan chose invalid input");
    lock_range_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        valid[0] |-> freq[0] >= lock_min_hz && freq[0] <= lock_max_hz)
        else $error("lock outside range");
    fast_reject_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        gate_end && edge_cnt[0] > 18'h00106 |=> !valid[0])
        else $error("too fast input locked");
    sync_cond_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        st[1] == in_sync |-> valid[1] && mode == st_slave && active == 2'h1)
        else $error("sync without lock");
    rate_now_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        wr_en && apb_in.paddr == ctrl_off && mode == st_master |=> rate == $past(apb_in.pwdata[ctrl_rate_lsb +: 18]))
        else $error("master rate not applied");
    cand_opt_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        !ctrl[ctrl_opt_bit] |-> !valid[2] && !valid[3])
        else $error("optional input used without module");
    ratio_out_a: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        wr_en && apb_in.paddr == ctrl_off |=> word_ratio_out == $past(apb_in.pwdata[ctrl_mult_lsb +: 3]))
        else $error("ratio not passed");

endmodule : sync_source_selector
`default_nettype wire

// file: sim/ref_source.sv
// Behavioural model of the external devices that send frame pulses to the selector
`timescale 1ns/1ps
`default_nettype none

module ref_source (
    // Run control and half period of each input, in ns
    input  wire logic [3:0]       run_in,
    input  wire logic [3:0][19:0] half_ns_in,
    // Frame pulses toward the selector
    output logic      [3:0]       tick_out
);

    ////////////////////////////////////////////////////////////////////////
    // One free-running pulse train per input; it has no tie to the core clock
    for (genvar k = 0; k < 4; k++) begin : g_src
        // An unplugged device leaves its line low and still
        always begin
            tick_out[k] = 1'b0;
            if (run_in[k] && half_ns_in[k] != 20'h0) begin
                #(half_ns_in[k]);
                tick_out[k] = 1'b1;
                #(half_ns_in[k]);
            end else begin
                @(run_in);
            end
        end
    end

endmodule : ref_source

`default_nettype wire

// file: sim/sync_source_selector_test.sv
// Self-checking testbench for the sync source selector
`timescale 1ns/1ps
`default_nettype none

module sync_source_selector_test;
    import sync_sel_pkg::*;

    // Expected read result: value, compared bits and error flag
    typedef struct packed {
        logic [31:0] exp;
        logic [31:0] mask;
        logic        err;
    } note_s;

    logic             core_clk = 1'b0; // 20 MHz clock
    logic             reset_n  = 1'b0; // Synchronous reset, active low
    logic             sys_tick = 1'b0; // Local sample tick
    apb_req_s         req      = '0;   // APB request
    apb_rsp_s         rsp;             // APB answer
    logic [3:0]       tick;            // Frame pulses from the far side
    logic [3:0]       run      = 4'h0; // Which far-side devices run
    logic [3:0][19:0] half     = '0;   // Their half periods in ns
    logic             slave;
    logic             irq;
    logic [1:0]       act;
    logic [17:0]      mrate;
    logic [2:0]       ratio;
    logic [17:0]      rnd_rate;        // Random master rate in the lock range
    int               bad_count   = 0;
    int               check_count = 0;
    int               cyc         = 0;
    int               lock_at     = 0; // Cycle count when the reference locked
    note_s            notes[$];        // Reads still waiting for their answer

    always #25 core_clk = ~core_clk;

    sync_source_selector i_sync_source_selector (
        .core_clk_in(core_clk), .reset_n_in(reset_n), .apb_in(req), .apb_out(rsp),
        .ref_tick_in(tick), .sys_tick_in(sys_tick), .slave_mode_out(slave),
        .active_ref_out(act), .master_rate_out(mrate), .word_ratio_out(ratio), .irq_out(irq));

    ref_source i_ref_source (.run_in(run), .half_ns_in(half), .tick_out(tick));

    ////////////////////////////////////////////////////////////////////////
    // Closing report, the only place the run ends
    task wrap_up();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up

    // Compare one value, report at once on mismatch
    task check(input string what, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : check

    // One APB transfer: setup, then access held until pready at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        req <= '{pwdata: d, paddr: a, pwrite: wr, psel: 1'b1, penable: 1'b0};
        @(posedge core_clk);
        req.penable <= 1'b1;
        do @(posedge core_clk); while (rsp.pready !== 1'b1);
        req <= '0;
    endtask : apb

    // Read with its expectation noted first for the watcher
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic er);
        notes.push_back('{e & m, m, er});
        apb(1'b0, a, 32'h0);
    endtask : rd

    // Wait, bounded, for the clock mode to reach a level, then check it
    task wait_slave(input logic lvl);
        int n;
        n = 0;
        while (slave !== lvl && n < 50000) begin
            @(negedge core_clk);
            n++;
        end
        check("slave mode", {31'h0, lvl}, {31'h0, slave});
    endtask : wait_slave

    ////////////////////////////////////////////////////////////////////////
    // Watcher: each completed read takes the oldest note off the queue
    always @(posedge core_clk) begin
        note_s n;
        if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite) begin
            n = notes.pop_front();
            check("read data", n.exp, rsp.prdata & n.mask);
            check("read error", {31'h0, n.err}, {31'h0, rsp.pslverr});
        end
    end

    // Random local tick; cycle ceiling cuts a hang short (a clean run takes ~60000 cycles)
    always @(posedge core_clk) begin
        sys_tick <= 1'($urandom);
        cyc <= cyc + 1;
        if (cyc == 110000) begin
            bad_count++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'hacf6ef16));
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        // Reset values, then an unmapped address
        rd(ctrl_off, ctrl_reset, 32'hffffffff, 1'b0);
        rd(rate_off, 32'(rate_reset), 32'hffffffff, 1'b0);
        rd(irq_en_off, 32'h0, 32'hf, 1'b0);
        rd(8'h40, 32'h0, 32'hffffffff, 1'b1);
        // Master mode: each written rate and ratio code applies at once
        for (int k = 0; k < 5; k++) begin
            rnd_rate = 18'(28000 + $urandom % 172001);
            apb(1'b1, ctrl_off, {2'b0, rnd_rate, 1'b0, 3'(k), 8'h0});
            repeat (2) @(negedge core_clk);
            check("master rate", 32'(rnd_rate), 32'(mrate));
            check("ratio code", 32'(k), 32'(ratio));
        end
        // Read-only rate register ignores the write
        apb(1'b1, rate_off, 32'h1234);
        rd(rate_off, 32'(rnd_rate), 32'hffffffff, 1'b0);
        // Word clock at 50 kHz, preferred serial input below range, video without module
        @(posedge core_clk);
        half <= {20'd0, 20'd10417, 20'd20833, 20'd10000};
        run  <= 4'b0111;
        apb(1'b1, ctrl_off, 32'h0bb8_0011);
        wait_slave(1'b1);
        lock_at = cyc;
        repeat (4) @(negedge core_clk);
        check("active ref", 32'(in_word), 32'(act));
        rd(status_off, 32'h400, 32'h73c, 1'b0);
        // The locking gate may be partial; read after the next full gate
        while (cyc < lock_at + 20005) @(posedge core_clk);
        rd(freq_off, 32'd50000, 32'hffffffff, 1'b0);
        // Stop just after a gate boundary, so no partial gate looks valid before the loss
        @(posedge core_clk);
        run <= 4'b0110;
        wait_slave(1'b0);
        repeat (2) @(negedge core_clk);
        check("fallback rate", 32'd48000, 32'(mrate));
        check("masked irq", 32'h0, {31'h0, irq});
        rd(irq_st_off, 32'he, 32'he, 1'b0);
        // Enable the fallback event, then clear it
        apb(1'b1, irq_en_off, 32'h2);
        repeat (2) @(negedge core_clk);
        check("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, irq_cl_off, 32'h2);
        repeat (2) @(negedge core_clk);
        check("irq cleared", 32'h0, {31'h0, irq});
        rd(irq_st_off, 32'h0, 32'h2, 1'b0);
        repeat (4) @(posedge core_clk);
        wrap_up();
    end

endmodule : sync_source_selector_test

`default_nettype wire
